//--- rtl/irtc_pkg.sv
// constants and carrier types of the infrared temperature clamp and relay
package irtc_pkg;

	////////////////////////////////////////////////////////////////////////
	// temperature coding: signed 12-bit, sixteen codes per degree
	localparam int TEMP_W = 12;
	localparam int OUT_W = 8;
	localparam int TEMP_PER_C = 16;
	localparam int OBJ_MIN_C = -20;
	localparam int OBJ_MAX_C = 120;
	localparam int AMB_MIN_C = 0;
	localparam int AMB_MAX_C = 50;
	localparam int THR_DEF_C = 50;
	localparam int HYST_DEF_C = 5;
	localparam logic signed [11:0] OBJ_MIN = 12'(OBJ_MIN_C * TEMP_PER_C);
	localparam logic signed [11:0] OBJ_MAX = 12'(OBJ_MAX_C * TEMP_PER_C);
	localparam logic signed [11:0] AMB_MIN = 12'(AMB_MIN_C * TEMP_PER_C);
	localparam logic signed [11:0] AMB_MAX = 12'(AMB_MAX_C * TEMP_PER_C);
	localparam logic [11:0] THR_RESET = 12'(THR_DEF_C * TEMP_PER_C);
	localparam logic [11:0] HYST_RESET = 12'(HYST_DEF_C * TEMP_PER_C);

	// linear scaling: code = (offset * factor) >> 16, factor rounded up
	localparam int FULL_CODE = 255;
	localparam int SCALE_SHIFT = 16;
	localparam int OBJ_SPAN = (OBJ_MAX_C - OBJ_MIN_C) * TEMP_PER_C;
	localparam int AMB_SPAN = (AMB_MAX_C - AMB_MIN_C) * TEMP_PER_C;
	localparam logic [14:0] OBJ_FACTOR =
		15'(((FULL_CODE << SCALE_SHIFT) + OBJ_SPAN - 1) / OBJ_SPAN);
	localparam logic [14:0] AMB_FACTOR =
		15'(((FULL_CODE << SCALE_SHIFT) + AMB_SPAN - 1) / AMB_SPAN);
	localparam logic [7:0] CODE_ZERO = 8'h00;
	localparam logic [7:0] CODE_FULL = 8'hff;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] THRESH_OFF = 8'h04;
	localparam logic [7:0] HYST_OFF = 8'h08;
	localparam logic [7:0] STATUS_OFF = 8'h0c;
	localparam logic [7:0] MASK_OFF = 8'h10;
	localparam logic [7:0] LEVEL_OFF = 8'h14;
	localparam logic [7:0] CODES_OFF = 8'h18;

	// fields
	localparam int CTRL_NONINV_BIT = 0;
	localparam logic CTRL_NONINV_RESET = 1'b0;
	localparam int EV_W = 4;
	localparam int EV_AMB_LOW = 0;
	localparam int EV_AMB_HIGH = 1;
	localparam int EV_OBJ_OUT = 2;
	localparam int EV_RELAY = 3;
	localparam logic [3:0] EV_RESET = 4'h0;

	////////////////////////////////////////////////////////////////////////
	// carrier from the compensation stage
	typedef struct packed {
		logic valid;
		logic signed [11:0] objTemp;
		logic signed [11:0] sensorTemp;
	} irtc_temps_s;

	typedef enum logic [2:0] {
		AMB_BELOW = 3'b001,
		AMB_INSIDE = 3'b010,
		AMB_ABOVE = 3'b100
	} irtc_amb_e;

endpackage

//--- rtl/irtc_top.sv
// range clamp, output coding and relay comparator of an ir thermometer
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/1ps
module irtc_top
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// converted temperatures
	input wire irtc_pkg::irtc_temps_s tempIn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// analogue channel codes and flag
	output logic [7:0] objectTempOutput,
	output logic [7:0] sensorTempOutput,
	output logic ambientLowFlag,
	// open-drain relay pin, enable low while pulling
	input wire logic relayDriveIn,
	output logic relayDriveOut,
	output logic relayDriveOen_n,
	// interrupt
	output logic irq
);
	import irtc_pkg::*;

	////////////////////////////////////////////////////////////////////////
	function automatic logic [7:0] scaleCode(input logic [11:0] off,
		input logic [14:0] factor);
		logic [26:0] prod;
		prod = {15'h0000, off} * {12'h000, factor};
		return prod[23:16];
	endfunction

	function automatic logic [11:0] offsetOf(input logic signed [11:0] v,
		input logic signed [11:0] lo);
		return 12'(v - lo);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// settings
	logic nonInv_q;
	logic [11:0] thresh_q;
	logic [11:0] hyst_q;
	logic [3:0] status_q;
	logic [3:0] mask_q;
	logic [3:0] events;
	logic wrEn;
	logic setupPh;

	assign setupPh = psel && !penable;
	assign wrEn = psel && penable && pready && pwrite;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			nonInv_q <= CTRL_NONINV_RESET;
			thresh_q <= THR_RESET;
			hyst_q <= HYST_RESET;
			mask_q <= EV_RESET;
		end else if (wrEn) begin
			// threshold and hysteresis stay live settings for the relay
			unique case (paddr)
				CTRL_OFF: nonInv_q <= pwdata[CTRL_NONINV_BIT];
				THRESH_OFF: thresh_q <= pwdata[11:0];
				HYST_OFF: hyst_q <= pwdata[11:0];
				MASK_OFF: mask_q <= pwdata[3:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// range classification
	irtc_amb_e ambState;
	logic objLow;
	logic objHigh;
	logic signed [11:0] objT;
	logic signed [11:0] sensT;

	assign objT = tempIn.objTemp;
	assign sensT = tempIn.sensorTemp;
	assign objLow = objT < OBJ_MIN;
	assign objHigh = objT > OBJ_MAX;

	always_comb begin
		if (sensT < AMB_MIN) begin
			ambState = AMB_BELOW;
		end else if (sensT > AMB_MAX) begin
			ambState = AMB_ABOVE;
		end else begin
			ambState = AMB_INSIDE;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output codes, refreshed on each converted sample
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			objectTempOutput <= CODE_ZERO;
			sensorTempOutput <= CODE_ZERO;
			ambientLowFlag <= 1'b0;
		end else if (tempIn.valid) begin
			unique case (ambState)
				AMB_BELOW: begin
					// object result is built on a false ambient, so hide it
					objectTempOutput <= CODE_ZERO;
					sensorTempOutput <= CODE_ZERO;
					ambientLowFlag <= 1'b1;
				end
				AMB_ABOVE: begin
					objectTempOutput <= CODE_FULL;
					sensorTempOutput <= CODE_FULL;
					ambientLowFlag <= 1'b0;
				end
				AMB_INSIDE: begin
					ambientLowFlag <= 1'b0;
					sensorTempOutput <=
						scaleCode(offsetOf(sensT, AMB_MIN), AMB_FACTOR);
					if (objLow) begin
						objectTempOutput <= CODE_ZERO;
					end else if (objHigh) begin
						objectTempOutput <= CODE_FULL;
					end else begin
						objectTempOutput <=
							scaleCode(offsetOf(objT, OBJ_MIN), OBJ_FACTOR);
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// relay comparator on the object temperature
	logic above_q;
	logic signed [12:0] objWide;
	logic signed [12:0] tripLevel;
	logic signed [12:0] releaseLevel;

	assign objWide = {objT[11], objT};
	assign tripLevel = $signed({thresh_q[11], thresh_q});
	assign releaseLevel = tripLevel - $signed({1'b0, hyst_q});

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			above_q <= 1'b0;
		end else if (tempIn.valid) begin
			if (!above_q && objWide > tripLevel) begin
				above_q <= 1'b1;
			end else if (above_q && objWide < releaseLevel) begin
				above_q <= 1'b0;
			end
		end
	end

	// relay on means the drain pulls low
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			relayDriveOen_n <= 1'b1;
			relayDriveOut <= 1'b0;
		end else begin
			relayDriveOen_n <= !(above_q ~^ nonInv_q);
			relayDriveOut <= 1'b0;
		end
	end

	// pin level read back, two stages since it is external
	logic relayMeta_q;
	logic relaySync_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			relayMeta_q <= 1'b1;
			relaySync_q <= 1'b1;
		end else begin
			relayMeta_q <= relayDriveIn;
			relaySync_q <= relayMeta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sticky events, write one to clear, a new event beats the clear
	logic ambLowPrev_q;
	logic ambHighPrev_q;
	logic relayPrev_q;

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ambLowPrev_q <= 1'b0;
			ambHighPrev_q <= 1'b0;
			relayPrev_q <= 1'b1;
		end else begin
			ambLowPrev_q <= ambientLowFlag;
			ambHighPrev_q <= (sensorTempOutput == CODE_FULL) &&
				(objectTempOutput == CODE_FULL);
			relayPrev_q <= relayDriveOen_n;
		end
	end

	always_comb begin
		events = EV_RESET;
		events[EV_AMB_LOW] = tempIn.valid && ambState == AMB_BELOW &&
			!ambLowPrev_q;
		events[EV_AMB_HIGH] = tempIn.valid && ambState == AMB_ABOVE &&
			!ambHighPrev_q;
		events[EV_OBJ_OUT] = tempIn.valid && ambState == AMB_INSIDE &&
			(objLow || objHigh);
		events[EV_RELAY] = relayPrev_q != relayDriveOen_n;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= EV_RESET;
		end else if (wrEn && paddr == STATUS_OFF) begin
			status_q <= (status_q & ~pwdata[3:0]) | events;
		end else begin
			status_q <= status_q | events;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status_q & mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb answer: data and ready prepared in the setup cycle
	logic [31:0] rdMux;
	logic hit;

	always_comb begin
		rdMux = 32'h00000000;
		hit = 1'b1;
		unique case (paddr)
			CTRL_OFF: rdMux[CTRL_NONINV_BIT] = nonInv_q;
			THRESH_OFF: rdMux[11:0] = thresh_q;
			HYST_OFF: rdMux[11:0] = hyst_q;
			STATUS_OFF: rdMux[3:0] = status_q;
			MASK_OFF: rdMux[3:0] = mask_q;
			LEVEL_OFF: rdMux[3:0] = {relaySync_q, !relayDriveOen_n,
				above_q, ambientLowFlag};
			CODES_OFF: rdMux[15:0] = {sensorTempOutput, objectTempOutput};
			default: hit = 1'b0;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= setupPh;
			pslverr <= setupPh && !hit;
			if (setupPh) begin
				// read data is a snapshot taken one cycle before the answer
				prdata <= (pwrite || !hit) ? 32'h00000000 : rdMux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	a_amb_low_zero: assert property (
		tempIn.valid && sensT < AMB_MIN |=> ambientLowFlag &&
		objectTempOutput == 8'h00 && sensorTempOutput == 8'h00)
		else $error("ambient low not forced");
	a_amb_high_full: assert property (
		tempIn.valid && sensT > AMB_MAX |=> !ambientLowFlag &&
		objectTempOutput == 8'hff && sensorTempOutput == 8'hff)
		else $error("ambient high not forced");
	a_amb_resume: assert property (
		tempIn.valid && !(sensT < AMB_MIN) && !(sensT > AMB_MAX) |=>
		!ambientLowFlag)
		else $error("flag stays after recovery");
	a_obj_clamp_low: assert property (
		tempIn.valid && sensT == AMB_MAX && objT < OBJ_MIN |=>
		objectTempOutput == 8'h00 && sensorTempOutput == 8'hff)
		else $error("object low clamp");
	a_obj_clamp_high: assert property (
		tempIn.valid && sensT == AMB_MIN && objT > OBJ_MAX |=>
		objectTempOutput == 8'hff && sensorTempOutput == 8'h00)
		else $error("object high clamp");
	a_obj_full_scale: assert property (
		tempIn.valid && sensT == AMB_MIN && objT == OBJ_MAX |=>
		objectTempOutput == 8'hff)
		else $error("object top not full scale");
	a_sens_full_scale: assert property (
		tempIn.valid && sensT == AMB_MAX |=> sensorTempOutput == 8'hff)
		else $error("sensor top not full scale");
	a_relay_trip: assert property (
		tempIn.valid && objWide > tripLevel && !nonInv_q ##1 !nonInv_q
		|=> relayDriveOen_n)
		else $error("inverting relay not off above");
	a_relay_noninv: assert property (
		tempIn.valid && objWide > tripLevel && nonInv_q ##1 nonInv_q
		|=> !relayDriveOen_n)
		else $error("non-inverting relay not on above");
	a_hyst_hold: assert property (
		above_q && tempIn.valid && objWide >= releaseLevel |=> above_q)
		else $error("released inside hysteresis");
	a_relay_release: assert property (
		above_q && tempIn.valid && objWide < releaseLevel |=> !above_q)
		else $error("comparator not released");
	a_relay_drain: assert property (!relayDriveOut)
		else $error("relay pin driven high");
	a_event_sticky: assert property (events != 4'h0 |=>
		(status_q & $past(events)) == $past(events))
		else $error("status event lost");
	a_irq_level: assert property ((status_q & mask_q) != 4'h0 |=> irq)
		else $error("irq missing");
	a_apb_ready: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("pready timing");
	a_apb_error: assert property (psel && !penable &&
		(paddr > CODES_OFF || paddr[1:0] != 2'b00) |=>
		pslverr && prdata == 32'h00000000)
		else $error("unmapped access not refused");

	c_amb_low: cover property (tempIn.valid && sensT < AMB_MIN);
	c_relay_cycle: cover property (above_q ##[1:50] !above_q);
	c_clear_race: cover property (wrEn && paddr == STATUS_OFF &&
		events != 4'h0);
	c_obj_clamp: cover property (tempIn.valid && sensT == AMB_MAX &&
		objT < OBJ_MIN);
	c_noninv_on: cover property (nonInv_q && !relayDriveOen_n);

endmodule

//--- verification/irtc_relay_model.sv
// far-side model: pulled-up relay pin and the relay that it switches
`timescale 1ns/1ps
module irtc_relay_model (
	// pin drive from the block
	input wire logic relayDriveOut,
	input wire logic relayDriveOen_n,
	// resolved pin and relay state
	output logic pinLevel,
	output logic relayOn
);
	// a released pin goes to the pull-up level, never to the last driven one
	assign pinLevel = relayDriveOen_n ? 1'b1 : relayDriveOut;
	assign relayOn = ~pinLevel;
endmodule

//--- verification/tb_ir_temp_range_clamp_relay_compare.sv
// self-checking bench for the ir clamp, output coding and relay block
`timescale 1ns/1ps
module tb_ir_temp_range_clamp_relay_compare;
	import irtc_pkg::*;
	logic sysClk, rstN, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [7:0] paddr, objOut, sensOut;
	logic [31:0] pwdata, prdata, rd;
	logic lowFlag, drvOut, oenN, pinLvl, relayOn;
	irtc_temps_s temps;
	int bad_count = 0;
	int n_tests = 0;
	int objTab[8] = '{0, -320, 1920, -321, 1921, 0, 0, 0};
	int sensTab[8] = '{400, 0, 0, 800, 0, -1, 801, 400};

	irtc_top uut (.sys_clk(sysClk), .rst_n(rstN), .tempIn(temps),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .objectTempOutput(objOut),
		.sensorTempOutput(sensOut), .ambientLowFlag(lowFlag),
		.relayDriveIn(pinLvl), .relayDriveOut(drvOut),
		.relayDriveOen_n(oenN), .irq(irq));
	irtc_relay_model relay (.relayDriveOut(drvOut),
		.relayDriveOen_n(oenN), .pinLevel(pinLvl), .relayOn(relayOn));

	initial begin
		sysClk = 0;
		forever #4 sysClk = ~sysClk;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d, mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	// entered just after a rising edge; ends one edge after release
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge sysClk);
		penable <= 1;
		// ends once pready is seen high; only the watchdog ends it if pready never comes
		do begin
			@(posedge sysClk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge sysClk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, rd, err);
	endtask

	task automatic rdChk(input string what, input logic [7:0] a,
		input logic [31:0] exp);
		apb(1'b0, a, 32'h0, rd, err);
		chk(what, exp, rd);
	endtask

	function automatic logic [7:0] code(int v, int lo, int hi, int f);
		if (v < lo)
			return CODE_ZERO;
		if (v > hi)
			return CODE_FULL;
		return 8'(((v - lo) * f) >> SCALE_SHIFT);
	endfunction

	task automatic sample(input int o, input int s);
		logic [7:0] eo, es;
		logic fl;
		temps <= '{1'b1, 12'(o), 12'(s)};
		@(posedge sysClk);
		temps.valid <= 1'b0;
		repeat (3) @(posedge sysClk);
		fl = s < int'(AMB_MIN);
		if (fl) begin
			eo = CODE_ZERO;
			es = CODE_ZERO;
		end else if (s > int'(AMB_MAX)) begin
			eo = CODE_FULL;
			es = CODE_FULL;
		end else begin
			eo = code(o, int'(OBJ_MIN), int'(OBJ_MAX), int'(OBJ_FACTOR));
			es = code(s, int'(AMB_MIN), int'(AMB_MAX), int'(AMB_FACTOR));
		end
		chk("objectTempOutput", 32'(eo), 32'(objOut));
		chk("sensorTempOutput", 32'(es), 32'(sensOut));
		chk("ambientLowFlag", 32'(fl), 32'(lowFlag));
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		#100us;
		bad_count++;
		print_verdict();
	end

	initial begin
		rstN = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 0;
		pwdata = 0;
		temps = '0;
		repeat (6) @(posedge sysClk);
		rstN <= 1;
		@(posedge sysClk);
		rdChk("ctrl", CTRL_OFF, 32'h0);
		rdChk("thresh", THRESH_OFF, 32'(THR_RESET));
		rdChk("hyst", HYST_OFF, 32'(HYST_RESET));
		rdChk("unmapped", 8'h1c, 32'h0);
		chk("pslverr", 32'h1, 32'(err));
		$display("test registers done");
		for (int i = 0; i < 8; i++)
			sample(objTab[i], sensTab[i]);
		rdChk("codes", CODES_OFF, 32'h00007f24);
		$display("test clamping done");
		chk("relayOn", 32'h1, 32'(relayOn));
		sample(801, 400);
		chk("relayOn", 32'h0, 32'(relayOn));
		sample(790, 400);
		chk("relayOn", 32'h0, 32'(relayOn));
		sample(720, 400);
		chk("relayOn", 32'h0, 32'(relayOn));
		sample(719, 400);
		chk("relayOn", 32'h1, 32'(relayOn));
		wr(CTRL_OFF, 32'h1);
		sample(724, 400);
		chk("relayOn", 32'h0, 32'(relayOn));
		sample(801, 400);
		chk("relayOn", 32'h1, 32'(relayOn));
		wr(THRESH_OFF, 32'h100);
		sample(100, 400);
		chk("relayOn", 32'h0, 32'(relayOn));
		sample(256, 400);
		chk("relayOn", 32'h0, 32'(relayOn));
		sample(257, 400);
		chk("relayOn", 32'h1, 32'(relayOn));
		rdChk("level", LEVEL_OFF, 32'h6);
		$display("test relay done");
		wr(STATUS_OFF, 32'hf);
		sample(0, -1);
		chk("irq", 32'h0, 32'(irq));
		apb(1'b0, STATUS_OFF, 32'h0, rd, err);
		chk("statusLow", 32'h1, 32'(rd[EV_AMB_LOW]));
		wr(MASK_OFF, 32'h1);
		repeat (2) @(posedge sysClk);
		chk("irq", 32'h1, 32'(irq));
		wr(STATUS_OFF, 32'h1);
		repeat (2) @(posedge sysClk);
		chk("irq", 32'h0, 32'(irq));
		$display("test interrupt done");
		rstN <= 0;
		@(posedge sysClk);
		rstN <= 1;
		repeat (2) @(posedge sysClk);
		chk("objectTempOutput", 32'h0, 32'(objOut));
		chk("ambientLowFlag", 32'h0, 32'(lowFlag));
		chk("relayOn", 32'h1, 32'(relayOn));
		rdChk("ctrl", CTRL_OFF, 32'h0);
		rdChk("thresh", THRESH_OFF, 32'(THR_RESET));
		$display("test reset done");
		print_verdict();
	end
endmodule
